// [verilog/cks_clock_ctrl.sv]
// Clock output skew, slew, enable and stop control with serial register port
//
// Functional notes
// - First delay register: link delay in 7:4, AGP in 3:0, both reset 1000.
// - Second delay register: free PCI delay 7:4, PCI 3:0, both reset 0100.
// - Slew field 01 strong, 10 weak, 00 and 11 normal.
// - First slew register: 24/48, AGP, link, reference fields; reset zero.
// - Second slew register: SDRAM, free PCI, PCI fields; bits 5:4 reserved.
// - Output gate bits 5..0 gate SDRAM, 48, 24/48 and three references; set.
// - Bit 7 is reference current control, reset 0; bit 6 reads multiplier level.
// - At power-up the dual pins are inputs, caught into a five-bit latch.
// - After power-on reset the dual pins drive their clock outputs.
// - PCI halt low parks PCI and stoppable free PCI low on next fall.
// - Processor halt stops only processor outputs marked stoppable.
// - After two rising processor edges with halt low, stop on the next rising edge.
// - Stopped processor pair rests with true high and complement low.
// - Stopped true output driven at multiplier times reference; complement floats.
// - Stopping leaves the drive current setting unchanged.
// - Output gate bit 1 enables the clock, 0 disables it.
// - Stop bit 0 means free running, 1 means stoppable by halt.
`default_nettype none

module cks_clock_ctrl
    import cks_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h5A  // Arbitrary bus address
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic current_multiplier_select,
    input wire logic pci_halt_n,
    input wire logic cpu_halt_n,
    input wire logic src_cpu,
    input wire logic src_pci,
    input wire logic src_ref,
    input wire logic src_48,
    input wire logic src_24_48,
    input wire logic src_sdram,
    input wire logic [STRAP_W-1:0] dual_pin_in,
    output logic [STRAP_W-1:0] dual_pin_out,
    output logic [STRAP_W-1:0] dual_pin_oe,
    output logic [5:0] pci_clock_out,
    output logic clk48_out,
    output logic clk24_48_out,
    output logic sdram_clk_out,
    output logic [1:0] cpu_clk_true,
    output logic [1:0] cpu_clk_comp,
    output logic [1:0] cpu_clk_comp_oe,
    output logic cpu_true_drive_mult,
    output logic iref_out_ctrl,
    output logic [STRAP_W-1:0] strap_latch,
    output logic [15:0] cpu_to_link_delay,
    output logic [15:0] cpu_to_agp_delay,
    output logic [15:0] cpu_to_freerun_pci_delay,
    output logic [15:0] cpu_to_pci_delay,
    output cks_slew_type [SLEW_FIELDS-1:0] slew_a_drive,
    output cks_slew_type [SLEW_FIELDS-1:0] slew_b_drive
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic cks_slew_type slew_decode(input logic [1:0] code);
        case (code)
            SLEW_CODE_STRONG: slew_decode = SLEW_STRONG;
            SLEW_CODE_WEAK: slew_decode = SLEW_WEAK;
            default: slew_decode = SLEW_NORMAL;
        endcase
    endfunction

    function automatic logic [15:0] delay_ps(input logic [DLY_W-1:0] code);
        delay_ps = 16'(DELAY_BASE_PS + DELAY_STEP_PS * {12'h000, code});
    endfunction

    function automatic logic in_map(input logic [7:0] idx);
        in_map = (idx >= REG_FIRST) && (idx <= REG_LAST);
    endfunction

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] regs [0:REG_COUNT-1];
    logic [7:0] next_regs [0:REG_COUNT-1];
    logic wr_stb;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;

    // Masked write; read-only and reserved bits never change
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            next_regs[i] = regs[i];
        end
        if (wr_stb && in_map(wr_idx)) begin
            next_regs[3'(wr_idx - REG_FIRST)] = (regs[3'(wr_idx - REG_FIRST)]
                & ~REG_WMASK[3'(wr_idx - REG_FIRST)])
                | (wr_data & REG_WMASK[3'(wr_idx - REG_FIRST)]);
        end
    end

    // Power-up defaults
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RESET[i];
            end
        end else begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // Readback with live multiplier level and fixed reserved value
    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (in_map(idx)) begin
            val = regs[3'(idx - REG_FIRST)];
        end
        if (idx == REG_SLEW_B) begin
            val[SLEW_B_RSVD_LSB +: 2] = SLEW_B_RSVD_VALUE;
        end
        if (idx == REG_OUT_GATE) begin
            val[MULT_RB_BIT] = current_multiplier_select;
        end
        read_reg = val;
    endfunction

    // ------------------------------------------------------------------
    // Serial management port
    // ------------------------------------------------------------------
    typedef enum {
        ST_IDLE, ST_ADDR, ST_AACK, ST_INDEX, ST_IACK,
        ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
    } cks_bus_state_type;

    cks_bus_state_type state, next_state;
    logic scl_q, sda_q, rw, drive_low, master_ack;
    logic next_rw, next_drive_low, next_master_ack;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg, tx, next_tx, idx, next_idx;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
    assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;

    // Bit and byte sequencing; data changes only while the clock is low
    always_comb begin
        next_state = state;
        next_rw = rw;
        next_drive_low = drive_low;
        next_master_ack = master_ack;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_tx = tx;
        next_idx = idx;
        wr_stb = 1'h0;
        if (scl_rise && state != ST_IDLE) begin
            next_shreg = {shreg[6:0], sda_in};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
            next_master_ack = ~sda_in;
        end
        if (bus_start) begin
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_drive_low = 1'h0;
        end else if (bus_stop) begin
            next_state = ST_IDLE;
            next_drive_low = 1'h0;
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        if (shreg[7:1] == DEV_ADDR) begin
                            next_state = ST_AACK;
                            next_rw = shreg[0];
                            next_drive_low = 1'h1;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_AACK, ST_IACK, ST_WACK: begin
                    next_bit_cnt = 4'h0;
                    if (state == ST_AACK && rw) begin
                        next_tx = read_reg(idx);
                        next_drive_low = ~next_tx[7];
                        next_state = ST_RDATA;
                    end else begin
                        next_drive_low = 1'h0;
                        next_state = (state == ST_AACK) ? ST_INDEX : ST_WDATA;
                    end
                end
                ST_INDEX: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        next_idx = shreg;
                        next_drive_low = 1'h1;
                        next_state = ST_IACK;
                    end
                end
                ST_WDATA: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        wr_stb = 1'h1;
                        next_idx = 8'(idx + 8'h01);
                        next_drive_low = 1'h1;
                        next_state = ST_WACK;
                    end
                end
                ST_RDATA: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        next_drive_low = 1'h0;
                        next_state = ST_RACK;
                    end else begin
                        next_tx = {tx[6:0], 1'h0};
                        next_drive_low = ~tx[6];
                    end
                end
                ST_RACK: begin
                    next_bit_cnt = 4'h0;
                    if (master_ack) begin
                        next_idx = 8'(idx + 8'h01);
                        next_tx = read_reg(next_idx);
                        next_drive_low = ~next_tx[7];
                        next_state = ST_RDATA;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    assign wr_idx = idx;
    assign wr_data = shreg;

    // Bus state registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            rw <= 1'h0;
            drive_low <= 1'h0;
            master_ack <= 1'h0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            idx <= 8'h00;
        end else begin
            state <= next_state;
            scl_q <= scl_in;
            sda_q <= sda_in;
            rw <= next_rw;
            drive_low <= next_drive_low;
            master_ack <= next_master_ack;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            tx <= next_tx;
            idx <= next_idx;
        end
    end

    // Open-drain: only ever pull low
    assign sda_out = 1'h0;
    assign sda_oe = drive_low;

    // ------------------------------------------------------------------
    // Strap capture and processor halt sampling
    // ------------------------------------------------------------------
    logic strap_done, next_strap_done, cpu_src_q, next_cpu_src_q;
    logic [STRAP_W-1:0] next_strap_latch;
    logic [1:0] halt_cnt, next_halt_cnt;
    logic cpu_stop_req;

    // Straps caught on the first edge after reset release, then pins drive
    always_comb begin
        next_strap_done = 1'h1;
        next_strap_latch = strap_done ? strap_latch : dual_pin_in;
        next_cpu_src_q = src_cpu;
        next_halt_cnt = halt_cnt;
        if (cpu_halt_n) begin
            next_halt_cnt = 2'h0;
        end else if (src_cpu && !cpu_src_q && halt_cnt != CPU_HALT_SAMPLES) begin
            next_halt_cnt = 2'(halt_cnt + 2'h1);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done <= 1'h0;
            strap_latch <= '0;
            cpu_src_q <= 1'h0;
            halt_cnt <= 2'h0;
        end else begin
            strap_done <= next_strap_done;
            strap_latch <= next_strap_latch;
            cpu_src_q <= next_cpu_src_q;
            halt_cnt <= next_halt_cnt;
        end
    end

    assign cpu_stop_req = !cpu_halt_n && halt_cnt == CPU_HALT_SAMPLES;

    // ------------------------------------------------------------------
    // Stop gates
    // ------------------------------------------------------------------
    cks_gate_if #(.WIDTH(2)) cpu_lanes ();
    cks_gate_if #(.WIDTH(8)) pci_lanes ();

    // Processor pair parks high on the true side
    assign cpu_lanes.src = {2{src_cpu}};
    assign cpu_lanes.en = 2'h3;
    assign cpu_lanes.stop_req = {2{cpu_stop_req}}
        & regs[3'(REG_STOP_CFG - REG_FIRST)][STOP_CPU0_BIT +: 2];
    assign cpu_lanes.park = 2'h3;

    // Lanes 5..0 plain PCI, 7..6 free-running PCI
    assign pci_lanes.src = {8{src_pci}};
    assign pci_lanes.en = 8'hFF;
    assign pci_lanes.stop_req = {{2{~pci_halt_n}}
        & regs[3'(REG_STOP_CFG - REG_FIRST)][STOP_PCIF0_BIT +: 2], {6{~pci_halt_n}}};
    assign pci_lanes.park = 8'h00;

    cks_clk_gate #(.WIDTH(2)) u_cpu_gate (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .lanes(cpu_lanes)
    );

    cks_clk_gate #(.WIDTH(8)) u_pci_gate (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .lanes(pci_lanes)
    );

    // ------------------------------------------------------------------
    // Gated outputs and decoded settings
    // ------------------------------------------------------------------
    logic [7:0] gate_reg;
    logic [2:0] ref_q, next_ref_q;
    logic next_clk48, next_clk24_48, next_sdram, next_mult, next_iref;
    logic [15:0] next_dly [0:3];
    cks_slew_type [SLEW_FIELDS-1:0] next_slew_a, next_slew_b;

    assign gate_reg = regs[3'(REG_OUT_GATE - REG_FIRST)];

    always_comb begin
        next_ref_q = {3{src_ref}} & gate_reg[GATE_REF0_BIT +: 3];
        next_clk48 = src_48 & gate_reg[GATE_48_BIT];
        next_clk24_48 = src_24_48 & gate_reg[GATE_24_48_BIT];
        next_sdram = src_sdram & gate_reg[GATE_SDRAM_BIT];
        next_mult = current_multiplier_select;
        next_iref = gate_reg[IREF_BIT];
        next_dly[0] = delay_ps(regs[0][DLY_HI_LSB +: DLY_W]);
        next_dly[1] = delay_ps(regs[0][DLY_LO_LSB +: DLY_W]);
        next_dly[2] = delay_ps(regs[1][DLY_HI_LSB +: DLY_W]);
        next_dly[3] = delay_ps(regs[1][DLY_LO_LSB +: DLY_W]);
        for (int i = 0; i < SLEW_FIELDS; i++) begin
            next_slew_a[i] = slew_decode(regs[3'(REG_SLEW_A - REG_FIRST)][SLEW_W*i +: SLEW_W]);
            next_slew_b[i] = slew_decode(regs[3'(REG_SLEW_B - REG_FIRST)][SLEW_W*i +: SLEW_W]);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_q <= 3'h0;
            clk48_out <= 1'h0;
            clk24_48_out <= 1'h0;
            sdram_clk_out <= 1'h0;
            cpu_true_drive_mult <= 1'h0;
            iref_out_ctrl <= 1'h0;
            cpu_to_link_delay <= 16'h0000;
            cpu_to_agp_delay <= 16'h0000;
            cpu_to_freerun_pci_delay <= 16'h0000;
            cpu_to_pci_delay <= 16'h0000;
            slew_a_drive <= '{default: SLEW_NORMAL};
            slew_b_drive <= '{default: SLEW_NORMAL};
        end else begin
            ref_q <= next_ref_q;
            clk48_out <= next_clk48;
            clk24_48_out <= next_clk24_48;
            sdram_clk_out <= next_sdram;
            cpu_true_drive_mult <= next_mult;
            iref_out_ctrl <= next_iref;
            cpu_to_link_delay <= next_dly[0];
            cpu_to_agp_delay <= next_dly[1];
            cpu_to_freerun_pci_delay <= next_dly[2];
            cpu_to_pci_delay <= next_dly[3];
            slew_a_drive <= next_slew_a;
            slew_b_drive <= next_slew_b;
        end
    end

    // Dual pins stay inputs until straps are held
    assign dual_pin_out = {pci_lanes.out[7:6], ref_q};
    assign dual_pin_oe = {STRAP_W{strap_done}};
    assign pci_clock_out = pci_lanes.out[5:0];
    assign cpu_clk_true = cpu_lanes.out;
    assign cpu_clk_comp = ~cpu_lanes.out & ~cpu_lanes.stopped;
    assign cpu_clk_comp_oe = ~cpu_lanes.stopped;

endmodule // cks_clock_ctrl

`default_nettype wire

// [verilog/cks_pkg.sv]
// Shared constants and types for the clock output control block
`default_nettype none

package cks_pkg;

    // ------------------------------------------------------------------
    // Register indices on the management bus
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_GRP_LINK_AGP = 8'h13;
    localparam logic [7:0] REG_GRP_PCI = 8'h14;
    localparam logic [7:0] REG_SLEW_A = 8'h15;
    localparam logic [7:0] REG_SLEW_B = 8'h16;
    localparam logic [7:0] REG_OUT_GATE = 8'h17;
    localparam logic [7:0] REG_STOP_CFG = 8'h18;
    localparam logic [7:0] REG_FIRST = REG_GRP_LINK_AGP;
    localparam logic [7:0] REG_LAST = REG_STOP_CFG;
    localparam int REG_COUNT = 6;

    // ------------------------------------------------------------------
    // Reset values and writable masks, in index order from REG_FIRST
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RESET [0:REG_COUNT-1] =
        '{8'h88, 8'h44, 8'h00, 8'h00, 8'h3F, 8'h03};
    localparam logic [7:0] REG_WMASK [0:REG_COUNT-1] =
        '{8'hFF, 8'hFF, 8'hFF, 8'hCF, 8'hBF, 8'h0F};
    localparam logic [1:0] SLEW_B_RSVD_VALUE = 2'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DLY_W = 4;
    localparam int DLY_HI_LSB = 4;
    localparam int DLY_LO_LSB = 0;
    localparam int SLEW_W = 2;
    localparam int SLEW_FIELDS = 4;
    localparam int SLEW_B_RSVD_LSB = 4;
    localparam int GATE_REF0_BIT = 0;
    localparam int GATE_48_BIT = 4;
    localparam int GATE_24_48_BIT = 3;
    localparam int GATE_SDRAM_BIT = 5;
    localparam int MULT_RB_BIT = 6;
    localparam int IREF_BIT = 7;
    localparam int STOP_CPU0_BIT = 0;
    localparam int STOP_PCIF0_BIT = 2;

    // ------------------------------------------------------------------
    // Delay scale and slew encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] DELAY_BASE_PS = 16'h073A;  // 1850 ps
    localparam logic [15:0] DELAY_STEP_PS = 16'h0096;  // 150 ps
    localparam logic [1:0] SLEW_CODE_STRONG = 2'h1;
    localparam logic [1:0] SLEW_CODE_WEAK = 2'h2;
    typedef enum logic [1:0] {SLEW_NORMAL, SLEW_STRONG, SLEW_WEAK} cks_slew_type;

    // ------------------------------------------------------------------
    // Stop handling and serial bus
    // ------------------------------------------------------------------
    localparam logic [1:0] CPU_HALT_SAMPLES = 2'h2;
    localparam int STRAP_W = 5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : cks_pkg

`default_nettype wire

// [verilog/cks_gate_if.sv]
// Lane bundle between the control logic and the clock stop gate
`default_nettype none

interface cks_gate_if #(parameter int WIDTH = 2);
    logic [WIDTH-1:0] src;
    logic [WIDTH-1:0] en;
    logic [WIDTH-1:0] stop_req;
    logic [WIDTH-1:0] park;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] stopped;
    modport ctrl (output src, output en, output stop_req, output park,
                  input out, input stopped);
    modport gate (input src, input en, input stop_req, input park,
                  output out, output stopped);
endinterface : cks_gate_if

`default_nettype wire

// [verilog/cks_clk_gate.sv]
// Glitch-free stop gate for a group of clock lanes
`default_nettype none

module cks_clk_gate
    import cks_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    cks_gate_if.gate lanes
);

    logic [WIDTH-1:0] src_q;
    logic [WIDTH-1:0] stopped;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] next_src_q;
    logic [WIDTH-1:0] next_stopped;
    logic [WIDTH-1:0] next_out;

    // ------------------------------------------------------------------
    // Park on the edge into the park level, leave on the edge out of it
    // ------------------------------------------------------------------
    // Waiting for the edge away from park means the first pulse is whole
    always_comb begin
        next_src_q = lanes.src;
        for (int i = 0; i < WIDTH; i++) begin
            if (stopped[i]) begin
                next_stopped[i] = lanes.stop_req[i] ||
                    !(lanes.src[i] != lanes.park[i] && src_q[i] == lanes.park[i]);
            end else begin
                next_stopped[i] = lanes.stop_req[i] &&
                    lanes.src[i] == lanes.park[i] && src_q[i] != lanes.park[i];
            end
            next_out[i] = next_stopped[i] ? lanes.park[i] : (lanes.src[i] & lanes.en[i]);
        end
    end

    // State registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_q <= '0;
            stopped <= '0;
            out_q <= '0;
        end else begin
            src_q <= next_src_q;
            stopped <= next_stopped;
            out_q <= next_out;
        end
    end

    assign lanes.out = out_q;
    assign lanes.stopped = stopped;

endmodule // cks_clk_gate

`default_nettype wire

// [dv/cks_clock_ctrl_properties.sv]
// Port assertions for the clock output control block
`default_nettype none
module cks_props
    import cks_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic current_multiplier_select,
    input wire logic pci_halt_n,
    input wire logic cpu_halt_n,
    input wire logic [STRAP_W-1:0] dual_pin_oe,
    input wire logic [STRAP_W-1:0] strap_latch,
    input wire logic [5:0] pci_clock_out,
    input wire logic [1:0] cpu_clk_true,
    input wire logic [1:0] cpu_clk_comp,
    input wire logic [1:0] cpu_clk_comp_oe,
    input wire logic cpu_true_drive_mult
);
    timeunit 1ns / 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // First edge after reset still samples reset values, so it is skipped
    pins_drive_a: assert property (!$past(sys_rst) |-> dual_pin_oe == 5'h1F)
        else $error("dual pins not driving");
    strap_hold_a: assert property (!$past(sys_rst, 2) |-> $stable(strap_latch))
        else $error("strap latch moved");
    comp_inv_a: assert property (cpu_clk_comp_oe[0] |-> cpu_clk_comp[0] ^ cpu_clk_true[0])
        else $error("pair not complementary");
    park_level_a: assert property (!$past(sys_rst) && !cpu_clk_comp_oe[0]
        |-> cpu_clk_true[0] && !cpu_clk_comp[0]) else $error("bad park level");
    mult_copy_a: assert property (!$past(sys_rst)
        |-> cpu_true_drive_mult == $past(current_multiplier_select)) else $error("drive level");
    pci_park_a: assert property ($fell(pci_clock_out[0]) && !$past(pci_halt_n)
        && !pci_halt_n |=> !pci_clock_out[0]) else $error("pci clock not parked");
    cpu_stop_a: assert property ($fell(cpu_clk_comp_oe[0])
        |-> !$past(cpu_halt_n) && !$past(cpu_halt_n, 4)) else $error("early stop");
    cpu_resume_a: assert property ($rose(cpu_clk_comp_oe[0]) && !$past(sys_rst, 2)
        |-> $past(cpu_halt_n)) else $error("resume while halted");
endmodule // cks_props
bind cks_clock_ctrl cks_props i_cks_props (.*);
`default_nettype wire

// [dv/cks_i2c_host.sv]
// Management bus host model for the serial register port
`default_nettype none
module cks_i2c_host #(
    parameter logic [6:0] DEV_ADDR = 7'h5A  // Arbitrary bus address
) (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    timeunit 1ns / 100ps;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Each level stands four clocks, well over the one the port needs
    task automatic ph(input logic c, input logic d);
        scl = c;
        sda = d;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    // Pairs of scl and sda levels, most significant pair first
    task automatic seq(input logic [7:0] p, input int n);
        for (int i = 0; i < n; i++) ph(p[7-2*i], p[6-2*i]);
    endtask
    // Data moves only while scl is low; the line is read at the end of high
    task automatic xb(input logic [8:0] o, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, o[i]);
            ph(1'b1, o[i]);
            r[i] = sda_line;
            ph(1'b0, o[i]);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [8:0] r;
        seq(8'h78, 4);
        xb({DEV_ADDR, 2'h1}, r);
        xb({idx, 1'b1}, r);
        xb({d, 1'b1}, r);
        seq(8'h2C, 3);
    endtask
    // Repeated start, then one byte closed by a refusal
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        logic [8:0] r;
        seq(8'h78, 4);
        xb({DEV_ADDR, 2'h1}, r);
        xb({idx, 1'b1}, r);
        seq(8'h78, 4);
        xb({DEV_ADDR, 2'h3}, r);
        xb(9'h1FF, r);
        d = r[8:1];
        seq(8'h2C, 3);
    endtask
endmodule // cks_i2c_host
`default_nettype wire

// [dv/cks_clock_ctrl_bench.sv]
// Self-checking bench for the clock output control block
`default_nettype none
module cks_clock_ctrl_bench import cks_pkg::*;;
    timeunit 1ns / 100ps;
    logic sys_clk = 1'b0, sys_rst = 1'b1, current_multiplier_select = 1'b1;
    logic pci_halt_n = 1'b1, cpu_halt_n = 1'b1, scl, sda, sda_oe, clk48_out, clk24_48_out;
    logic sdram_clk_out, cpu_true_drive_mult, iref_out_ctrl;
    logic [4:0] strap_latch, dual_pin_oe, dual_pin_out;
    logic [5:0] pci_clock_out;
    logic [1:0] cpu_clk_true, cpu_clk_comp, cpu_clk_comp_oe;
    logic [15:0] cpu_to_link_delay, cpu_to_agp_delay, cpu_to_freerun_pci_delay, cpu_to_pci_delay;
    logic [15:0] cyc = 16'h0;
    logic [7:0] v;
    cks_slew_type [3:0] slew_a_drive, slew_b_drive;
    int bad_count = 0, checks_done = 0;
    wire logic sda_line = sda & ~sda_oe;
    always #5 sys_clk = ~sys_clk;
    cks_i2c_host i_cks_i2c_host (.*);
    cks_clock_ctrl i_cks_clock_ctrl (.*, .scl_in(scl), .sda_in(sda_line), .sda_out(),
        .src_cpu(cyc[1]), .src_pci(cyc[2]), .src_ref(cyc[3]), .src_48(cyc[1]),
        .src_24_48(cyc[2]), .src_sdram(cyc[0]), .dual_pin_in(5'h15));
    // Free count makes the source clocks and cuts a hang short
    always @(posedge sys_clk) begin
        cyc <= #1 cyc + 16'h1;
        if (cyc == 16'h9C40) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] dly(input logic [3:0] c);
        return 16'h073A + 16'h0096 * c;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic t_reset();
        logic [7:0] e [5] = '{8'h88, 8'h44, 8'h00, 8'h00, 8'h7F};
        chk(cpu_to_link_delay, dly(4'h8));
        chk(cpu_to_pci_delay, dly(4'h4));
        chk(strap_latch, 5'h15);
        for (int i = 0; i < 5; i++) begin
            i_cks_i2c_host.rd(8'h13 + 8'(i), v);
            chk(v, e[i]);
        end
    endtask
    // Extreme delay codes and every slew code, reserved bits written as ones
    task automatic t_fields();
        i_cks_i2c_host.wr(8'h13, 8'h0F);
        i_cks_i2c_host.wr(8'h14, 8'hF0);
        i_cks_i2c_host.wr(8'h15, 8'h1B);
        i_cks_i2c_host.wr(8'h16, 8'h76);
        chk(cpu_to_link_delay, dly(4'h0));
        chk(cpu_to_agp_delay, dly(4'hF));
        chk(cpu_to_freerun_pci_delay, dly(4'hF));
        chk(slew_a_drive, 8'h18);
        chk(slew_b_drive, 8'h46);
        i_cks_i2c_host.rd(8'h16, v);
        chk(v, 8'h46);
    endtask
    task automatic t_gate();
        current_multiplier_select = 1'b0;
        i_cks_i2c_host.wr(8'h17, 8'h80);
        i_cks_i2c_host.rd(8'h17, v);
        chk(v, 8'h80);
        chk(iref_out_ctrl, 1'b1);
        repeat (8) begin
            wt(1);
            chk({clk48_out, clk24_48_out, sdram_clk_out, dual_pin_out[2:0]}, 6'h0);
        end
        current_multiplier_select = 1'b1;
        i_cks_i2c_host.wr(8'h17, 8'h3F);
    endtask
    // Only processor lane 0 stoppable; both halts held, then released
    task automatic t_stop();
        i_cks_i2c_host.wr(8'h18, 8'h01);
        pci_halt_n = 1'b0;
        cpu_halt_n = 1'b0;
        wt(30);
        repeat (8) begin
            wt(1);
            chk(pci_clock_out, 6'h0);
            chk({cpu_clk_comp_oe, cpu_clk_true[0], cpu_clk_comp[0]}, 4'hA);
            chk({cpu_true_drive_mult, cpu_clk_comp[1]}, {1'b1, ~cpu_clk_true[1]});
        end
        pci_halt_n = 1'b1;
        cpu_halt_n = 1'b1;
        wt(30);
        chk(cpu_clk_comp_oe, 2'h3);
    endtask
    initial begin
        wt(10);
        sys_rst = 1'b0;
        wt(2);
        t_reset();
        t_fields();
        t_gate();
        t_stop();
        print_verdict();
    end
endmodule // cks_clock_ctrl_bench
`default_nettype wire
